// file: logic/strap_pkg.sv
// Overview of operation
// - during system reset every strap pin is undriven so board resistors set its level.
// - each strap pin level is captured as system reset is released.
// - after reset release every strap pin becomes a driven output.
// - each strap has a weak pull; unstrapped pins latch the default level.
// - emission filter strap 0 enables filtering, 1 disables it (default).
// - flow control strap, all ports: 0 disabled, 1 enabled (default).
// - link-up strap 0 fast link-up without negotiation or crossover; 1 normal (default).
// - normal mode negotiation pair: 00 reserved, 01 forced 100 half, 10 nand tree, 11 auto.
// - fast mode runs full duplex; low negotiation strap 0 crossed, 1 straight.
// - management pair: 00 mdio, 01 i2c, upper bit set spi (default).
// - switch start strap 0 holds forwarding until software start; 1 forwards at once.
// - port 6 interface pair: 00 rgmii (default), 01 rmii, 11 mii, 10 reserved.
// - port 6 submode 0 mii phy or rmii clock out; 1 mii mac or rmii clock in.
// - port 6 speed strap 0 selects 1000, 1 selects 100; 100 advised for mii/rmii.
// - in-band management strap 0 disables (default), 1 enables.
// - both sgmii straps must be 1; a 0 on either is invalid.
// - software reset also releases and re-samples every strap.
package strap_pkg;

  localparam int NSTRAP = 15;
  localparam int EMI_BIT = 0;
  localparam int FC_BIT = 1;
  localparam int LINKUP_BIT = 2;
  localparam int NEG_L_BIT = 3;
  localparam int NEG_H_BIT = 4;
  localparam int MGMT_L_BIT = 5;
  localparam int MGMT_H_BIT = 6;
  localparam int START_BIT = 7;
  localparam int P6IF_L_BIT = 8;
  localparam int P6IF_H_BIT = 9;
  localparam int P6SUB_BIT = 10;
  localparam int P6SPD_BIT = 11;
  localparam int INBAND_BIT = 12;
  localparam int SGC_BIT = 13;
  localparam int SGJ_BIT = 14;

  // 1 = weak pull-up, 0 = weak pull-down; equals each strap's default
  localparam logic [NSTRAP-1:0] STRAP_DEFAULT = 15'h60df;

  localparam logic [1:0] NEG_RSVD = 2'h0;
  localparam logic [1:0] NEG_FORCE = 2'h1;
  localparam logic [1:0] NEG_NAND = 2'h2;
  localparam logic [1:0] NEG_AUTO = 2'h3;
  localparam logic [1:0] P6_RGMII = 2'h0;
  localparam logic [1:0] P6_RMII = 2'h1;
  localparam logic [1:0] P6_RSVD = 2'h2;
  localparam logic [1:0] P6_MII = 2'h3;

  typedef enum logic [1:0] {
    MGMT_MDIO = 2'b00,
    MGMT_I2C  = 2'b01,
    MGMT_SPI  = 2'b10
  } mgmt_t;

  typedef enum logic [1:0] {
    ST_SAMPLE = 2'b00,
    ST_RUN    = 2'b01,
    ST_HIZ    = 2'b10
  } strap_state_t;

  typedef struct packed {
    logic       emission_filter_en;
    logic       flow_ctrl_en;
    logic       fast_linkup;
    logic       aneg_en;
    logic       auto_mdix_en;
    logic       force_100_half;
    logic       full_duplex;
    logic       mdix_crossed;
    logic       nand_tree_en;
    logic       neg_reserved;
    mgmt_t      mgmt_mode;
    logic [1:0] p6_mode;
    logic       p6_if_reserved;
    logic       p6_mac_mode;
    logic       p6_refclk_out_en;
    logic       p6_refclk_in_en;
    logic       p6_speed_100;
    logic       p6_speed_mismatch;
    logic       inband_mgmt_en;
    logic       sgmii_invalid;
  } cfg_t;

  localparam int CFG_W = $bits(cfg_t);

  // apb map, byte addresses
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_CTRL = 8'h04;
  localparam logic [7:0] ADDR_CFG = 8'h08;
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_RESTRAP_BIT = 1;
  localparam int STAT_RUN_BIT = 24;

  // release time of the pins on a software re-strap
  localparam int CLK_PERIOD_NS = 40;
  localparam int STRAP_HIZ_NS = 400;
  localparam int HIZ_CYCLES = (STRAP_HIZ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] HIZ_LAST = 8'(HIZ_CYCLES - 1);

endpackage

// file: logic/strap_if.sv
`timescale 1ns/1ps
interface strap_if;
  logic [strap_pkg::NSTRAP-1:0] raw;
  strap_pkg::cfg_t              cfg;
  modport owner (output raw, input cfg);
  modport decoder (input raw, output cfg);
endinterface

// file: logic/strap_decode.sv
`timescale 1ns/1ps
module strap_decode (
  strap_if.decoder bus
);

  function automatic logic [1:0] pair(input logic hi, input logic lo);
    pair = {hi, lo};
  endfunction

  logic [1:0] neg;
  logic [1:0] p6;
  logic       fast;

  always_comb begin
    neg  = pair(bus.raw[strap_pkg::NEG_H_BIT], bus.raw[strap_pkg::NEG_L_BIT]);
    p6   = pair(bus.raw[strap_pkg::P6IF_H_BIT], bus.raw[strap_pkg::P6IF_L_BIT]);
    fast = ~bus.raw[strap_pkg::LINKUP_BIT];
    bus.cfg = '0;
    bus.cfg.emission_filter_en = ~bus.raw[strap_pkg::EMI_BIT];
    bus.cfg.flow_ctrl_en = bus.raw[strap_pkg::FC_BIT];
    bus.cfg.fast_linkup = fast;
    if (fast) begin
      // negotiation and crossover off, high strap of the pair unused
      bus.cfg.full_duplex = 1'b1;
      bus.cfg.mdix_crossed = ~bus.raw[strap_pkg::NEG_L_BIT];
    end else begin
      bus.cfg.aneg_en = (neg == strap_pkg::NEG_AUTO);
      bus.cfg.force_100_half = (neg == strap_pkg::NEG_FORCE);
      bus.cfg.nand_tree_en = (neg == strap_pkg::NEG_NAND);
      bus.cfg.neg_reserved = (neg == strap_pkg::NEG_RSVD);
      bus.cfg.auto_mdix_en = (neg == strap_pkg::NEG_AUTO) || (neg == strap_pkg::NEG_FORCE);
    end
    if (bus.raw[strap_pkg::MGMT_H_BIT]) begin
      bus.cfg.mgmt_mode = strap_pkg::MGMT_SPI;
    end else if (bus.raw[strap_pkg::MGMT_L_BIT]) begin
      bus.cfg.mgmt_mode = strap_pkg::MGMT_I2C;
    end else begin
      bus.cfg.mgmt_mode = strap_pkg::MGMT_MDIO;
    end
    bus.cfg.p6_mode = p6;
    bus.cfg.p6_if_reserved = (p6 == strap_pkg::P6_RSVD);
    // submode means nothing for rgmii
    bus.cfg.p6_mac_mode = (p6 == strap_pkg::P6_MII) && bus.raw[strap_pkg::P6SUB_BIT];
    bus.cfg.p6_refclk_out_en = (p6 == strap_pkg::P6_RMII) && !bus.raw[strap_pkg::P6SUB_BIT];
    bus.cfg.p6_refclk_in_en = (p6 == strap_pkg::P6_RMII) && bus.raw[strap_pkg::P6SUB_BIT];
    bus.cfg.p6_speed_100 = bus.raw[strap_pkg::P6SPD_BIT];
    // advisory only: gigabit on mii/rmii is allowed but flagged
    bus.cfg.p6_speed_mismatch = ((p6 == strap_pkg::P6_MII) || (p6 == strap_pkg::P6_RMII))
                                && !bus.raw[strap_pkg::P6SPD_BIT];
    bus.cfg.inband_mgmt_en = bus.raw[strap_pkg::INBAND_BIT];
    bus.cfg.sgmii_invalid = !bus.raw[strap_pkg::SGC_BIT] || !bus.raw[strap_pkg::SGJ_BIT];
  end

endmodule

// file: logic/reset_strap_sampler.sv
`timescale 1ns/1ps
module reset_strap_sampler (
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [7:0]                   paddr,
  input  wire logic [31:0]                  pwdata,
  output logic      [31:0]                  prdata,
  output logic                              pready,
  output logic                              pslverr,
  input  wire logic [strap_pkg::NSTRAP-1:0] strap_in,
  input  wire logic [strap_pkg::NSTRAP-1:0] func_out,
  output logic      [strap_pkg::NSTRAP-1:0] strap_out,
  output logic      [strap_pkg::NSTRAP-1:0] strap_oe,
  output logic      [strap_pkg::NSTRAP-1:0] strap_pull_up,
  output logic                              emission_filter_en,
  output logic                              flow_ctrl_en,
  output logic                              fast_linkup,
  output logic                              aneg_en,
  output logic                              auto_mdix_en,
  output logic                              force_100_half,
  output logic                              full_duplex,
  output logic                              mdix_crossed,
  output logic                              nand_tree_en,
  output logic      [1:0]                   mgmt_mode,
  output logic                              switch_fwd_en,
  output logic      [1:0]                   p6_mode,
  output logic                              p6_mac_mode,
  output logic                              p6_refclk_out_en,
  output logic                              p6_refclk_in_en,
  output logic                              p6_speed_100,
  output logic                              inband_mgmt_en,
  output logic                              sgmii_invalid,
  output logic                              strap_valid
);

  strap_pkg::strap_state_t          state_q;
  logic [7:0]                       hiz_cnt_q;
  logic [strap_pkg::NSTRAP-1:0]     raw_q;
  logic [strap_pkg::NSTRAP-1:0]     oe_q;
  logic [strap_pkg::NSTRAP-1:0]     out_q;
  logic [strap_pkg::NSTRAP-1:0]     pull_q;
  strap_pkg::cfg_t                  cfg_q;
  logic                             start_q;
  logic                             fwd_q;
  logic                             valid_q;
  logic                             pready_q;
  logic                             pslverr_q;
  logic [31:0]                      prdata_q;
  logic                             apb_setup_done;
  logic                             apb_access;
  logic                             ctrl_wr;
  logic                             restrap_req;

  strap_if sif ();

  assign sif.raw = raw_q;

  strap_decode u_decode (
    .bus (sif)
  );

  // one wait state: pready rises one cycle into the access phase
  assign apb_setup_done = psel && penable && !pready_q;
  assign apb_access     = psel && penable && pready_q;
  assign ctrl_wr        = apb_access && pwrite && (paddr == strap_pkg::ADDR_CTRL);
  assign restrap_req    = ctrl_wr && pwdata[strap_pkg::CTRL_RESTRAP_BIT];

  // sampling sequence; reset lands in ST_SAMPLE so the first edge after release latches
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= strap_pkg::ST_SAMPLE;
    end else begin
      case (state_q)
        strap_pkg::ST_SAMPLE: begin
          state_q <= strap_pkg::ST_RUN;
        end
        strap_pkg::ST_RUN: begin
          if (restrap_req) begin
            state_q <= strap_pkg::ST_HIZ;
          end
        end
        strap_pkg::ST_HIZ: begin
          if (hiz_cnt_q == strap_pkg::HIZ_LAST) begin
            state_q <= strap_pkg::ST_SAMPLE;
          end
        end
        default: begin
          state_q <= strap_pkg::ST_SAMPLE;
        end
      endcase
    end
  end

  // gives the weak pulls time to settle the pins after a software re-strap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hiz_cnt_q <= 8'h00;
    end else if (state_q == strap_pkg::ST_HIZ) begin
      hiz_cnt_q <= hiz_cnt_q + 8'h01;
    end else begin
      hiz_cnt_q <= 8'h00;
    end
  end

  // latch only in ST_SAMPLE; later pin activity is never seen
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      raw_q <= strap_pkg::STRAP_DEFAULT;
    end else if (state_q == strap_pkg::ST_SAMPLE) begin
      raw_q <= strap_in;
    end
  end

  // pins undriven from reset until the sample edge, and again during a re-strap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oe_q <= '0;
    end else if (state_q == strap_pkg::ST_SAMPLE) begin
      oe_q <= '1;
    end else if (restrap_req && state_q == strap_pkg::ST_RUN) begin
      oe_q <= '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_q <= '0;
    end else begin
      out_q <= func_out;
    end
  end

  // pad pull selection, fixed to each strap's default level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pull_q <= strap_pkg::STRAP_DEFAULT;
    end else begin
      pull_q <= strap_pkg::STRAP_DEFAULT;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= '0;
    end else begin
      cfg_q <= sif.cfg;
    end
  end

  // software start bit; cleared by a re-strap like any other reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_q <= 1'b0;
    end else if (restrap_req) begin
      start_q <= 1'b0;
    end else if (ctrl_wr) begin
      start_q <= pwdata[strap_pkg::CTRL_START_BIT];
    end
  end

  // no forwarding before the straps are known
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fwd_q   <= 1'b0;
      valid_q <= 1'b0;
    end else begin
      fwd_q   <= (state_q == strap_pkg::ST_RUN)
                 && (raw_q[strap_pkg::START_BIT] || start_q);
      valid_q <= (state_q == strap_pkg::ST_RUN);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= apb_setup_done;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      if (apb_setup_done) begin
        if (paddr == strap_pkg::ADDR_STATUS) begin
          if (!pwrite) begin
            prdata_q <= 32'({valid_q, 9'h000, raw_q});
          end
        end else if (paddr == strap_pkg::ADDR_CTRL) begin
          if (!pwrite) begin
            prdata_q <= 32'({1'b0, start_q});
          end
        end else if (paddr == strap_pkg::ADDR_CFG) begin
          if (!pwrite) begin
            prdata_q <= 32'(cfg_q);
          end
        end else begin
          pslverr_q <= 1'b1;
        end
      end
    end
  end

  assign prdata           = prdata_q;
  assign pready           = pready_q;
  assign pslverr          = pslverr_q;
  assign strap_out        = out_q;
  assign strap_oe         = oe_q;
  assign strap_pull_up    = pull_q;
  assign emission_filter_en = cfg_q.emission_filter_en;
  assign flow_ctrl_en     = cfg_q.flow_ctrl_en;
  assign fast_linkup      = cfg_q.fast_linkup;
  assign aneg_en          = cfg_q.aneg_en;
  assign auto_mdix_en     = cfg_q.auto_mdix_en;
  assign force_100_half   = cfg_q.force_100_half;
  assign full_duplex      = cfg_q.full_duplex;
  assign mdix_crossed     = cfg_q.mdix_crossed;
  assign nand_tree_en     = cfg_q.nand_tree_en;
  assign mgmt_mode        = cfg_q.mgmt_mode;
  assign switch_fwd_en    = fwd_q;
  assign p6_mode          = cfg_q.p6_mode;
  assign p6_mac_mode      = cfg_q.p6_mac_mode;
  assign p6_refclk_out_en = cfg_q.p6_refclk_out_en;
  assign p6_refclk_in_en  = cfg_q.p6_refclk_in_en;
  assign p6_speed_100     = cfg_q.p6_speed_100;
  assign inband_mgmt_en   = cfg_q.inband_mgmt_en;
  assign sgmii_invalid    = cfg_q.sgmii_invalid;
  assign strap_valid      = valid_q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_pins_released_hiz: assert property (
    (state_q != strap_pkg::ST_RUN) |-> (oe_q == '0))
    else $error("strap pin driven outside run state");

  chk_sample_latch_pins: assert property (
    (state_q == strap_pkg::ST_SAMPLE) |=> (raw_q == $past(strap_in)))
    else $error("strap level not latched at sample edge");

  chk_pins_driven_after: assert property (
    (state_q == strap_pkg::ST_SAMPLE) |=> (oe_q == '1) [*2])
    else $error("strap pins not driven after sampling");

  chk_restrap_sequence_bound: assert property (
    (restrap_req && state_q == strap_pkg::ST_RUN)
      |=> (state_q == strap_pkg::ST_HIZ) ##[9:11] (state_q == strap_pkg::ST_SAMPLE))
    else $error("software re-strap did not re-sample in time");

  chk_latched_values_stable: assert property (
    (state_q != strap_pkg::ST_SAMPLE) |=> $stable(raw_q))
    else $error("latched strap changed outside sampling");

  chk_switch_fwd_gate: assert property (
    (state_q == strap_pkg::ST_RUN)
      |=> (fwd_q == ($past(raw_q[strap_pkg::START_BIT]) || $past(start_q))))
    else $error("forwarding enable does not follow start strap or bit");

  chk_sgmii_invalid_flag: assert property (
    1'b1 |=> (cfg_q.sgmii_invalid ==
      (!$past(raw_q[strap_pkg::SGC_BIT]) || !$past(raw_q[strap_pkg::SGJ_BIT]))))
    else $error("sgmii invalid flag wrong");

  chk_mgmt_mode_decode: assert property (
    // cfg_q resets to zero, so the decode is only meaningful once straps are valid
    valid_q && $past(raw_q[strap_pkg::MGMT_H_BIT])
      |-> (cfg_q.mgmt_mode == strap_pkg::MGMT_SPI))
    else $error("management select not spi with upper strap set");

  chk_aneg_decode_normal: assert property (
    (valid_q && $past(raw_q[strap_pkg::LINKUP_BIT]) && $past(raw_q[strap_pkg::NEG_H_BIT])
      && $past(raw_q[strap_pkg::NEG_L_BIT])) |-> (cfg_q.aneg_en && !cfg_q.nand_tree_en))
    else $error("negotiation not enabled for pair 11");

endmodule

// file: dv/strap_board.sv
`timescale 1ns/1ps
module strap_board (
  input  wire logic [strap_pkg::NSTRAP-1:0] ext_fit,
  input  wire logic [strap_pkg::NSTRAP-1:0] ext_val,
  input  wire logic [strap_pkg::NSTRAP-1:0] pull_up,
  input  wire logic [strap_pkg::NSTRAP-1:0] pin_out,
  input  wire logic [strap_pkg::NSTRAP-1:0] pin_oe,
  output logic      [strap_pkg::NSTRAP-1:0] pin_level
);
  // the driver beats a fitted resistor, which beats the weak pull
  always_comb begin
    for (int i = 0; i < strap_pkg::NSTRAP; i++) begin
      if (pin_oe[i])
        pin_level[i] = pin_out[i];
      else if (ext_fit[i])
        pin_level[i] = ext_val[i];
      else
        pin_level[i] = pull_up[i];
    end
  end
endmodule

// file: dv/tb_reset_strap_sampler.sv
`timescale 1ns/1ps
module tb_reset_strap_sampler;
  // defaults that the weak pulls give with nothing fitted
  localparam logic [14:0] DEF = 15'h60df;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [14:0] strap_in;
  logic [14:0] func_out = 15'h0;
  logic [14:0] strap_out;
  logic [14:0] strap_oe;
  logic [14:0] strap_pull_up;
  logic        emission_filter_en, flow_ctrl_en, fast_linkup, aneg_en, auto_mdix_en;
  logic        force_100_half, full_duplex, mdix_crossed, nand_tree_en, switch_fwd_en;
  logic        p6_mac_mode, p6_refclk_out_en, p6_refclk_in_en, p6_speed_100;
  logic        inband_mgmt_en, sgmii_invalid, strap_valid;
  logic [1:0]  mgmt_mode;
  logic [1:0]  p6_mode;
  logic [20:0] got;
  logic [14:0] ext_fit = 15'h0;
  logic [14:0] ext_val = 15'h0;
  logic [14:0] s;
  logic [14:0] r;
  logic [31:0] rd;
  logic        er;
  logic [5:0]  k;
  integer      seed = 73;
  int          errors = 0;
  int          cmp_count = 0;

  always #20 pclk = ~pclk;

  reset_strap_sampler u_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .strap_in, .func_out, .strap_out, .strap_oe, .strap_pull_up, .emission_filter_en,
    .flow_ctrl_en, .fast_linkup, .aneg_en, .auto_mdix_en, .force_100_half, .full_duplex,
    .mdix_crossed, .nand_tree_en, .mgmt_mode, .switch_fwd_en, .p6_mode, .p6_mac_mode,
    .p6_refclk_out_en, .p6_refclk_in_en, .p6_speed_100, .inband_mgmt_en, .sgmii_invalid,
    .strap_valid
  );

  strap_board u_board (
    .ext_fit, .ext_val, .pull_up(strap_pull_up), .pin_out(strap_out), .pin_oe(strap_oe),
    .pin_level(strap_in)
  );

  assign got = {emission_filter_en, flow_ctrl_en, fast_linkup, aneg_en, auto_mdix_en,
                force_100_half, full_duplex, mdix_crossed, nand_tree_en, mgmt_mode,
                switch_fwd_en, p6_mode, p6_mac_mode, p6_refclk_out_en, p6_refclk_in_en,
                p6_speed_100, inband_mgmt_en, sgmii_invalid, strap_valid};

  task automatic wrap_up;
    $display("compares %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // mask drops outputs that reserved or unused codes leave open
  function automatic void model(input logic [14:0] v, input bit st,
                                output logic [20:0] ev, output logic [20:0] mv);
    int neg;
    int p6;
    bit fast;
    neg = {v[4], v[3]};
    p6 = {v[9], v[8]};
    fast = !v[2];
    mv = '1;
    ev[20] = !v[0];
    ev[19] = v[1];
    ev[18] = fast;
    ev[17] = !fast && neg == 3;
    ev[16] = !fast;
    ev[15] = !fast && neg == 1;
    ev[14] = fast;
    ev[13] = fast && !v[3];
    ev[12] = !fast && neg == 2;
    ev[11:10] = v[6] ? 2'b10 : {1'b0, v[5]};
    ev[9] = v[7] | st;
    ev[8:7] = v[9:8];
    ev[6] = p6 == 3 && v[10];
    ev[5] = p6 == 1 && !v[10];
    ev[4] = p6 == 1 && v[10];
    ev[3] = v[11];
    ev[2] = v[12];
    ev[1] = !(v[13] && v[14]);
    ev[0] = 1'b1;
    mv[13] = fast;
    if (!fast && !v[3])
      mv[16] = 1'b0;
    if (!fast && neg == 0)
      mv[17:15] = 3'b000;
    if (!fast && neg == 0)
      mv[12] = 1'b0;
  endfunction

  task automatic apb(input bit wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rv, output logic ev);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge pclk);
    end
    if (n == 50)
      errors++;
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic do_reset(input int n);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (n) @(posedge pclk);
    @(negedge pclk);
    check("oe_in_reset", 32'h0, {17'h0, strap_oe});
    @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    @(negedge pclk);
  endtask

  task automatic verify(input logic [14:0] v, input bit st);
    logic [20:0] ev;
    logic [20:0] mv;
    logic [20:0] em;
    logic [20:0] gm;
    model(v, st, ev, mv);
    em = ev & mv;
    gm = got & mv;
    check("link", {20'h0, em[20:9]}, {20'h0, gm[20:9]});
    check("port", {23'h0, em[8:0]}, {23'h0, gm[8:0]});
    check("oe_run", 32'h7fff, {17'h0, strap_oe});
    apb(1'b0, strap_pkg::ADDR_STATUS, 32'h0, rd, er);
    check("status", {7'h0, 1'b1, 9'h0, v}, rd);
  endtask

  initial begin
    #(40 * 20000);
    errors++;
    wrap_up();
  end

  initial begin
    do_reset(16);
    check("pulls", {17'h0, DEF}, {17'h0, strap_pull_up});
    verify(DEF, 1'b0);
    for (int i = 0; i < 40; i++) begin
      k = 6'(i);
      r = 15'($random(seed));
      r[4:2] = k[2:0];
      r[6:5] = k[4:3];
      r[9:8] = k[3:2];
      r[10] = k[0];
      s = (i < 32) ? 15'h7fff : 15'($random(seed));
      ext_val <= r;
      ext_fit <= s;
      s = (s & r) | (~s & DEF);
      do_reset(3);
      verify(s, 1'b0);
    end
    // pins now drive; board and function activity must not move the latch
    for (int i = 0; i < 8; i++) begin
      r = 15'($random(seed));
      @(posedge pclk);
      func_out <= r;
      ext_val <= ~ext_val;
      @(posedge pclk);
      @(negedge pclk);
      check("pin_out", {17'h0, r}, {17'h0, strap_out});
    end
    verify(s, 1'b0);
    ext_fit <= 15'h7fff;
    ext_val <= DEF & 15'h7f7f;
    do_reset(3);
    verify(DEF & 15'h7f7f, 1'b0);
    apb(1'b1, strap_pkg::ADDR_CTRL, 32'h1, rd, er);
    // forwarding enable follows the start bit one edge after the write
    repeat (2) @(negedge pclk);
    verify(DEF & 15'h7f7f, 1'b1);
    apb(1'b0, strap_pkg::ADDR_CTRL, 32'h0, rd, er);
    check("ctrl", 32'h1, rd);
    ext_val <= 15'h2a5a;
    apb(1'b1, strap_pkg::ADDR_CTRL, 32'h2, rd, er);
    @(negedge pclk);
    check("oe_restrap", 32'h0, {17'h0, strap_oe});
    for (int n = 0; n < 40 && strap_oe !== 15'h7fff; n++)
      @(negedge pclk);
    @(negedge pclk);
    verify(15'h2a5a, 1'b0);
    // fast link-up, straight mdi, spi, reserved port 6 code, one sgmii strap low
    apb(1'b0, strap_pkg::ADDR_CFG, 32'h0, rd, er);
    check("cfg", 32'h0038_8a89, rd);
    apb(1'b0, 8'h0c, 32'h0, rd, er);
    check("unmapped_err", 32'h1, {31'h0, er});
    check("unmapped_data", 32'h0, rd);
    wrap_up();
  end
endmodule
